// ==== ssc_pkg.sv ====
/*
  ssc_pkg: timing constants for the asynchronous
  sram controller.
  assumes a 25 MHz system clock; source figures in ns, derived counts in clocks.
*/
package ssc_pkg;
  localparam int CLK_PERIOD_NS = 40;
  // fast grade figures
  localparam int FAST_READ_CYCLE_NS       = 55;
  localparam int FAST_WRITE_CYCLE_NS      = 55;
  localparam int FAST_WRITE_PULSE_MIN_NS  = 40;
  localparam int FAST_SELECT_TO_WR_END_NS = 45;
  localparam int FAST_LANE_TO_WR_END_NS   = 45;
  localparam int FAST_DATA_SETUP_NS       = 25;
  // slow grade figures, then the grade-independent data hi-z delay
  localparam int SLOW_READ_CYCLE_NS       = 70;
  localparam int SLOW_WRITE_CYCLE_NS      = 70;
  localparam int SLOW_WRITE_PULSE_MIN_NS  = 50;
  localparam int SLOW_SELECT_TO_WR_END_NS = 60;
  localparam int SLOW_LANE_TO_WR_END_NS   = 60;
  localparam int SLOW_DATA_SETUP_NS       = 30;
  localparam int DEV_HIZ_AFTER_WE_NS      = 20;

  // whole cycles, rounded up, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int FAST_READ_CYC  = ns_to_cyc(FAST_READ_CYCLE_NS);
  localparam int SLOW_READ_CYC  = ns_to_cyc(SLOW_READ_CYCLE_NS);
  localparam int FAST_WRITE_CYC = ns_to_cyc(FAST_WRITE_CYCLE_NS);
  localparam int SLOW_WRITE_CYC = ns_to_cyc(SLOW_WRITE_CYCLE_NS);
  localparam int FAST_WPULSE_CYC = ns_to_cyc(FAST_WRITE_PULSE_MIN_NS);
  localparam int SLOW_WPULSE_CYC = ns_to_cyc(SLOW_WRITE_PULSE_MIN_NS);
  localparam int FAST_SEL_CYC   = ns_to_cyc(FAST_SELECT_TO_WR_END_NS);
  localparam int SLOW_SEL_CYC   = ns_to_cyc(SLOW_SELECT_TO_WR_END_NS);
  localparam int FAST_LANE_CYC  = ns_to_cyc(FAST_LANE_TO_WR_END_NS);
  localparam int SLOW_LANE_CYC  = ns_to_cyc(SLOW_LANE_TO_WR_END_NS);
  localparam int FAST_SETUP_CYC = ns_to_cyc(FAST_DATA_SETUP_NS);
  localparam int SLOW_SETUP_CYC = ns_to_cyc(SLOW_DATA_SETUP_NS);
  localparam int HIZ_CYC        = ns_to_cyc(DEV_HIZ_AFTER_WE_NS);

  localparam int CNT_W = 4;
  localparam logic [3:0] RESET_CNT = 4'h0;
endpackage

// ==== ssc_timer.sv ====
/*
  ssc_timer: loadable down counter giving a done level at zero.
  assumes the caller loads it one cycle before it is watched.
*/
`timescale 1ns/1ps
module ssc_timer #(
  parameter int W = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);
  logic [W-1:0] cnt_ff;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cnt_ff <= '0;
    else if (load)
      cnt_ff <= load_val;
    else if (cnt_ff != '0)
      cnt_ff <= cnt_ff - W'(1);
  end

  assign done = (cnt_ff == '0);
endmodule

// ==== ssc_ctrl.sv ====
/*
  ssc_ctrl: clocked controller for a 256K x 16 asynchronous static
  memory with active-low select, output enable, write enable and
  two byte-lane enables.
  assumes a 25 MHz clock, synchronous reset, and that the memory
  pins are registered straight onto the board.
*/
//Notes on behaviour
//[R1] memory writes when select, we, lane low
//[R2] write starts with all active; one ending
//[R3] data stable around edge ending the write
//[R4] write enable high throughout every read
//[R5] address valid before select falls
//[R6] read cycle at least 55/70 ns
//[R7] write cycle at least 55/70 ns
//[R8] write pulse at least 40/50 ns
//[R9] select low 45/60 ns before end
//[R10] lanes low 45/60 ns before end
//[R11] memory floats data after we falls
//[R12] wait a read cycle after retention
//[R13] low lane bits 0-7, high 8-15
//[R14] standby when deselected or no lanes
//[R15] read drives enabled lanes with oe low
//[R16] durations rounded up to whole clocks
`timescale 1ns/1ps
module ssc_ctrl #(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 16
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              slow_grade,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [1:0]        req_lanes,
  input  wire logic              retention_exit,
  output logic                   req_ready,
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   chip_select_n,
  output logic                   out_enable_n,
  output logic                   write_enable_n,
  output logic                   low_lane_enable_n,
  output logic                   high_lane_enable_n,
  input  wire logic [DATA_W-1:0] mem_dq_in,
  output logic [DATA_W-1:0]      mem_dq_out,
  output logic                   mem_dq_oe
);
  typedef enum {ST_IDLE, ST_RSETUP, ST_READ, ST_WSETUP, ST_WPULSE, ST_WEND, ST_RECOVER} ssc_state_t;
  ssc_state_t state_ff;

  logic                       tmr_load;
  logic [ssc_pkg::CNT_W-1:0] tmr_val;
  logic                       tmr_done;
  logic [DATA_W-1:0]          nxt_rd_data;
  logic [ssc_pkg::CNT_W-1:0] rd_cyc;
  logic [ssc_pkg::CNT_W-1:0] wr_pulse_cyc;
  logic [ssc_pkg::CNT_W-1:0] rec_cyc;
  logic                       req_take;

  // per-grade counts, rounded up
  assign rd_cyc       = slow_grade ? 4'(ssc_pkg::SLOW_READ_CYC) : 4'(ssc_pkg::FAST_READ_CYC);    // R6 R16
  // pulse covers we width, select/lane lead and write cycle together
  assign wr_pulse_cyc = slow_grade ? 4'(ssc_pkg::SLOW_SEL_CYC) : 4'(ssc_pkg::FAST_SEL_CYC);      // R7 R8 R9 R10 R16
  assign rec_cyc      = rd_cyc;                                                                  // R12
  assign req_take     = req_valid && req_ready;

  ssc_timer #(.W(ssc_pkg::CNT_W)) u_timer (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  always_comb
  begin
    tmr_load = 1'b0;
    tmr_val  = ssc_pkg::RESET_CNT;
    case (state_ff)
      ST_RSETUP:
      begin
        tmr_load = 1'b1;
        tmr_val  = 4'(rd_cyc - 4'h1);
      end
      ST_WSETUP:
      begin
        tmr_load = 1'b1;
        tmr_val  = 4'(wr_pulse_cyc - 4'h1);
      end
      ST_IDLE:
      begin
        tmr_load = retention_exit;
        tmr_val  = rec_cyc;
      end
      default:
      begin
        tmr_load = 1'b0;
      end
    endcase
  end

  // main sequencer
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_ff <= ST_IDLE;
    else
    begin
      case (state_ff)
        ST_IDLE:
          if (retention_exit)
            state_ff <= ST_RECOVER;                                  // R12
          else if (req_take)
            state_ff <= req_write ? ST_WSETUP : ST_RSETUP;
        ST_RECOVER:
          if (tmr_done)
            state_ff <= ST_IDLE;
        ST_RSETUP:
          state_ff <= ST_READ;
        ST_READ:
          if (tmr_done)
            state_ff <= ST_IDLE;
        ST_WSETUP:
          state_ff <= ST_WPULSE;
        ST_WPULSE:
          if (tmr_done)
            state_ff <= ST_WEND;
        ST_WEND:
          state_ff <= ST_IDLE;
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  assign req_ready = (state_ff == ST_IDLE) && !retention_exit;

  // address and lanes latched at request, before select falls
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mem_addr           <= '0;
      low_lane_enable_n  <= 1'b1;
      high_lane_enable_n <= 1'b1;
    end
    else if (req_take)
    begin
      mem_addr           <= req_addr;                              // R5
      low_lane_enable_n  <= ~req_lanes[0];                         // R13
      high_lane_enable_n <= ~req_lanes[1];                         // R13
    end
    else if (state_ff == ST_WEND || (state_ff == ST_READ && tmr_done))
    begin
      low_lane_enable_n  <= 1'b1;                                  // R14
      high_lane_enable_n <= 1'b1;
    end
  end

  // strobes
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      chip_select_n  <= 1'b1;
      out_enable_n   <= 1'b1;
      write_enable_n <= 1'b1;
    end
    else
    begin
      case (state_ff)
        ST_RSETUP:
        begin
          chip_select_n  <= 1'b0;                                  // R5
          out_enable_n   <= 1'b0;                                  // R15
          write_enable_n <= 1'b1;                                  // R4
        end
        ST_WSETUP:
        begin
          chip_select_n  <= 1'b0;                                  // R2 R9
          write_enable_n <= 1'b0;                                  // R2 R8
          out_enable_n   <= 1'b1;
        end
        ST_WPULSE:
          if (tmr_done)
            write_enable_n <= 1'b1;                                // R2 R3
        ST_READ:
          if (tmr_done)
          begin
            chip_select_n <= 1'b1;
            out_enable_n  <= 1'b1;
          end
        default:
        begin
          chip_select_n  <= 1'b1;
          out_enable_n   <= 1'b1;
          write_enable_n <= 1'b1;
        end
      endcase
    end
  end

  // write data driven from setup until a cycle after we rises
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mem_dq_out <= '0;
      mem_dq_oe  <= 1'b0;
    end
    else if (req_take && req_write)
    begin
      mem_dq_out <= req_wdata;                                     // R3
      mem_dq_oe  <= 1'b1;
    end
    else if (state_ff == ST_WEND)
      mem_dq_oe  <= 1'b0;                                          // R3
  end

  // read capture, per enabled lane
  always_comb
  begin
    nxt_rd_data = '0;
    nxt_rd_data[7:0]  = low_lane_enable_n  ? 8'h00 : mem_dq_in[7:0];   // R13
    nxt_rd_data[15:8] = high_lane_enable_n ? 8'h00 : mem_dq_in[15:8];  // R13
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end
    else
    begin
      rd_valid <= (state_ff == ST_READ) && tmr_done;
      if ((state_ff == ST_READ) && tmr_done)
        rd_data <= nxt_rd_data;
    end
  end

  // low pulse length and cycle count helpers
  // counts hold the number of edges each strobe was seen low
  logic [3:0] we_low_cnt_ff;
  logic [3:0] cs_low_cnt_ff;
  logic [3:0] lane_low_cnt_ff;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      we_low_cnt_ff   <= 4'h0;
      cs_low_cnt_ff   <= 4'h0;
      lane_low_cnt_ff <= 4'h0;
    end
    else
    begin
      we_low_cnt_ff   <= write_enable_n ? 4'h0 : 4'(we_low_cnt_ff + 4'h1);
      cs_low_cnt_ff   <= chip_select_n  ? 4'h0 : 4'(cs_low_cnt_ff + 4'h1);
      lane_low_cnt_ff <= (low_lane_enable_n && high_lane_enable_n) ? 4'h0 : 4'(lane_low_cnt_ff + 4'h1);
    end
  end

  AST_WE_PULSE_MIN: assert property (@(posedge sys_clk) disable iff (rst) // R8
    $rose(write_enable_n) |->
      we_low_cnt_ff >= (slow_grade ? 4'(ssc_pkg::SLOW_WPULSE_CYC) : 4'(ssc_pkg::FAST_WPULSE_CYC)))
    else $error("write pulse too short");
  AST_CS_BEFORE_END: assert property (@(posedge sys_clk) disable iff (rst) // R9
    $rose(write_enable_n) |->
      cs_low_cnt_ff >= (slow_grade ? 4'(ssc_pkg::SLOW_SEL_CYC) : 4'(ssc_pkg::FAST_SEL_CYC)))
    else $error("select too short before write end");
  AST_LANE_DURING_WE: assert property (@(posedge sys_clk) disable iff (rst) // R10
    $rose(write_enable_n) |->
      lane_low_cnt_ff >= (slow_grade ? 4'(ssc_pkg::SLOW_LANE_CYC) : 4'(ssc_pkg::FAST_LANE_CYC)))
    else $error("lanes too short before write end");
  AST_WE_HIGH_READ: assert property (@(posedge sys_clk) disable iff (rst) // R4
    !out_enable_n |-> write_enable_n)
    else $error("write enable low in read");
  AST_ADDR_STABLE: assert property (@(posedge sys_clk) disable iff (rst) // R5
    !chip_select_n && !$rose(!chip_select_n) |-> $stable(mem_addr))
    else $error("address moved while selected");
  AST_READ_LEN: assert property (@(posedge sys_clk) disable iff (rst) // R6
    $fell(out_enable_n) |-> !out_enable_n [*2])
    else $error("read cycle too short");
  AST_DATA_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // R3
    $rose(write_enable_n) |-> mem_dq_oe && $stable(mem_dq_out))
    else $error("write data not held at write end");
  AST_RECOVERY: assert property (@(posedge sys_clk) disable iff (rst) // R12
    retention_exit && state_ff == ST_IDLE |=> chip_select_n [*2])
    else $error("access during retention recovery");
  AST_RD_VALID: assert property (@(posedge sys_clk) disable iff (rst) // R15
    $rose(out_enable_n) |-> rd_valid)
    else $error("read data missing at read end");

  COV_READ: cover property (@(posedge sys_clk) disable iff (rst) rd_valid);
  COV_WRITE: cover property (@(posedge sys_clk) disable iff (rst) $rose(write_enable_n));
  COV_RECOVER: cover property (@(posedge sys_clk) disable iff (rst) state_ff == ST_RECOVER);
endmodule

// ==== ssc_sram_model.sv ====
/*
  ssc_sram_model: behavioural 16-bit asynchronous static memory, 256 words.
  assumes the bench resolves the shared data bus and feeds it in here.
*/
`timescale 1ns/1ps
module ssc_sram_model (
  input  wire logic [17:0] mem_addr,
  input  wire logic        chip_select_n,
  input  wire logic        out_enable_n,
  input  wire logic        write_enable_n,
  input  wire logic        low_lane_enable_n,
  input  wire logic        high_lane_enable_n,
  input  wire logic [15:0] dq_drive,
  output logic      [15:0] dq_read
);
  logic [15:0] mem_ff [0:255];
  logic        write_on;
  logic        read_on;
  logic [15:0] word;

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem_ff[i] = 16'h0000;
  end

  assign write_on = !chip_select_n && !write_enable_n && (!low_lane_enable_n || !high_lane_enable_n);
  assign read_on  = !chip_select_n && write_enable_n && !out_enable_n;
  assign word     = mem_ff[mem_addr[7:0]];

  // bytes follow the bus for as long as the overlap lasts
  always @*
  begin
    if (write_on)
    begin
      if (!low_lane_enable_n)
        mem_ff[mem_addr[7:0]][7:0] = dq_drive[7:0];
      if (!high_lane_enable_n)
        mem_ff[mem_addr[7:0]][15:8] = dq_drive[15:8];
    end
  end

  // released lanes show the inverse word, never a stale copy
  assign dq_read[7:0]  = (read_on && !low_lane_enable_n) ? word[7:0] : ~word[7:0];
  assign dq_read[15:8] = (read_on && !high_lane_enable_n) ? word[15:8] : ~word[15:8];
endmodule

// ==== tb.sv ====
/*
  tb: self-checking bench for ssc_ctrl against a behavioural memory.
  assumes a 25 MHz clock and the request handshake of the controller.
*/
`timescale 1ns/1ps
module tb;
  localparam int P = ssc_pkg::CLK_PERIOD_NS;
  logic        sys_clk;
  logic        rst;
  logic        slow_grade;
  logic        req_valid;
  logic        req_write;
  logic [17:0] req_addr;
  logic [15:0] req_wdata;
  logic [1:0]  req_lanes;
  logic        retention_exit;
  logic        req_ready;
  logic        rd_valid;
  logic [15:0] rd_data;
  logic [17:0] mem_addr;
  logic        chip_select_n;
  logic        out_enable_n;
  logic        write_enable_n;
  logic        low_lane_enable_n;
  logic        high_lane_enable_n;
  logic [15:0] mem_dq_in;
  logic [15:0] mem_dq_out;
  logic        mem_dq_oe;
  logic [15:0] bus;
  int          err_count;
  int          compares;

  // undriven bus floats to the inverse of the last write data
  assign bus = mem_dq_oe ? mem_dq_out : ~mem_dq_out;

  ssc_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .slow_grade(slow_grade), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
    .retention_exit(retention_exit), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .mem_addr(mem_addr), .chip_select_n(chip_select_n), .out_enable_n(out_enable_n),
    .write_enable_n(write_enable_n), .low_lane_enable_n(low_lane_enable_n),
    .high_lane_enable_n(high_lane_enable_n), .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out),
    .mem_dq_oe(mem_dq_oe));

  ssc_sram_model u_mem (.mem_addr(mem_addr), .chip_select_n(chip_select_n), .out_enable_n(out_enable_n),
    .write_enable_n(write_enable_n), .low_lane_enable_n(low_lane_enable_n),
    .high_lane_enable_n(high_lane_enable_n), .dq_drive(bus), .dq_read(mem_dq_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t ns: %s got %h want %h", $time, what, seen, exp);
    end
  endtask

  task wrap_up;
    $display("comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one request, then eight cycles of watching the memory pins
  task automatic do_req(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [1:0] l,
                        output logic [15:0] rd, output int sel, output int wel, output int bad);
    int   n;
    logic ended;
    n = 0;
    ended = 1'b0;
    sel = 0;
    wel = 0;
    bad = 0;
    rd = 'x;
    @(negedge sys_clk);
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 50) check(req_ready, 1'b1, "ready never came");
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= a;
    req_wdata <= d;
    req_lanes <= l;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    repeat (8)
    begin
      @(negedge sys_clk);
      if (write_enable_n === 1'b0) wel++;
      else if (wel > 0) ended = 1'b1;
      if (chip_select_n === 1'b0 && !ended) sel++;
      if (chip_select_n === 1'b0 && (mem_addr !== a || (!w && write_enable_n !== 1'b1))) bad++;
      if (rd_valid === 1'b1) rd = rd_data;
    end
  endtask

  task automatic t_reset;
    check({chip_select_n, out_enable_n, write_enable_n, low_lane_enable_n, high_lane_enable_n}, 5'h1f, "strobes");
    check({mem_dq_oe, rd_valid, req_ready}, 3'h1, "flags");
    check(mem_addr, 18'h00000, "address");
    $display("test reset done");
  endtask

  task automatic t_word(input logic g);
    logic [15:0] rd;
    int          sel;
    int          wel;
    int          bad;
    @(posedge sys_clk);
    slow_grade <= g;
    do_req(1'b1, 18'h3ff12, 16'ha55a, 2'h3, rd, sel, wel, bad);
    check(wel * P >= (g ? 50 : 40), 1, "write pulse");
    check(sel * P >= (g ? 60 : 45), 1, "select to end");
    check(sel * P >= (g ? 70 : 55), 1, "write cycle");
    check(bad, 0, "write address");
    do_req(1'b0, 18'h3ff12, 16'h0000, 2'h3, rd, sel, wel, bad);
    check(rd, 16'ha55a, "read back");
    check(sel * P >= (g ? 70 : 55), 1, "read cycle");
    check(bad, 0, "read strobes");
    $display("test word grade %0d done", g);
  endtask

  task automatic t_lanes;
    logic [15:0] rd;
    int          sel;
    int          wel;
    int          bad;
    do_req(1'b1, 18'h00012, 16'h11c3, 2'h1, rd, sel, wel, bad);
    do_req(1'b0, 18'h00012, 16'h0000, 2'h3, rd, sel, wel, bad);
    check(rd, 16'ha5c3, "low lane write");
    do_req(1'b1, 18'h00012, 16'h7766, 2'h2, rd, sel, wel, bad);
    do_req(1'b0, 18'h00012, 16'h0000, 2'h1, rd, sel, wel, bad);
    check(rd, 16'h00c3, "low lane read");
    do_req(1'b0, 18'h00012, 16'h0000, 2'h2, rd, sel, wel, bad);
    check(rd, 16'h7700, "high lane read");
    $display("test lanes done");
  endtask

  task automatic t_retention;
    logic [15:0] rd;
    int          sel;
    int          wel;
    int          bad;
    int          low;
    low = 0;
    sel = 0;
    @(posedge sys_clk);
    retention_exit <= 1'b1;
    req_valid      <= 1'b1;
    req_write      <= 1'b0;
    @(posedge sys_clk);
    retention_exit <= 1'b0;
    req_valid      <= 1'b0;
    repeat (10)
    begin
      @(negedge sys_clk);
      if (req_ready !== 1'b1) low++;
      if (chip_select_n !== 1'b1) sel++;
    end
    check(low * P >= (slow_grade ? 70 : 55), 1, "recovery wait");
    check(sel, 0, "refused request");
    do_req(1'b0, 18'h3ff12, 16'h0000, 2'h3, rd, sel, wel, bad);
    check(rd, 16'ha55a, "read after recovery");
    $display("test retention done");
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (3000) @(posedge sys_clk);
    err_count++;
    $display("wrong value at %0t ns: watchdog expired", $time);
    wrap_up;
  end

  initial
  begin
    err_count = 0;
    compares = 0;
    rst = 1'b1;
    slow_grade = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 18'h00000;
    req_wdata = 16'h0000;
    req_lanes = 2'h0;
    retention_exit = 1'b0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    t_reset;
    t_word(1'b0);
    t_lanes;
    t_word(1'b1);
    t_retention;
    wrap_up;
  end
endmodule
